/* sgol_ecc_track.sv */
// Tracks first and repeated programming of each 16-byte one-time chunk.
// Assumes one beat per byte and a first-beat marker for each command.
`timescale 1ns/100ps
module sgol_ecc_track (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic prog,
  input wire logic first,
  input wire logic [5:0] chunk,
  input wire logic [5:0] sel_chunk,
  output logic ecc_off
);
  import sgol_pkg::*;

  logic [63:0] written_reg;
  logic [63:0] off_reg;
  logic [5:0] last_chunk_reg;

  // A chunk loses its code when a later command programs it again; beats
  // of one page command inside the same chunk count as one operation.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      written_reg <= 64'h0;
      off_reg <= 64'h0;
      last_chunk_reg <= 6'h00;
    end else if (prog) begin
      written_reg[chunk] <= 1'b1;
      last_chunk_reg <= chunk;
      if (written_reg[chunk] && (first || last_chunk_reg != chunk)) begin
        off_reg[chunk] <= 1'b1;
      end
    end
  end

  // Code state of the chunk being read.
  assign ecc_off = off_reg[sel_chunk];

endmodule : sgol_ecc_track

/* sgol_host_model.sv */
// Host-side model that sends command beats into the guard block.
// Assumes the bench calls its beat task and that clk runs free.
`timescale 1ns/100ps
module sgol_host_model (
  input wire logic clk,
  output logic cmd_valid,
  output logic cmd_first,
  output sgol_pkg::sgol_byte_t cmd_op,
  output sgol_pkg::sgol_addr_t cmd_addr,
  output sgol_pkg::sgol_byte_t cmd_data
);
  import sgol_pkg::*;

  // ----------------------------------------------------------------------
  // Idle lines
  // ----------------------------------------------------------------------
  // Nothing is requested until the bench asks for a beat.
  initial begin
    cmd_valid = 1'b0;
    cmd_first = 1'b0;
    cmd_op = 8'h00;
    cmd_addr = 32'h0000_0000;
    cmd_data = 8'h00;
  end

  // ----------------------------------------------------------------------
  // Beat driver
  // ----------------------------------------------------------------------
  // One beat is launched on a falling edge and held over one rising edge.
  // Released qualifiers are cleared and the payload inverted so a stale value is never trusted.
  // Opcodes are the documented lock, guard and one-time ones.
  // Guard reads and writes use their own opcodes.
  // One-time reads use the fast-read style framing.
  // A chunk is programmed once unless the bench asks for more.
  task automatic beat(input sgol_byte_t op, input sgol_addr_t addr,
                      input sgol_byte_t data, input logic first);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_first = first;
    cmd_op = op;
    cmd_addr = addr;
    cmd_data = data;
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_first = 1'b0;
    cmd_op = ~op;
    cmd_addr = ~addr;
    cmd_data = ~data;
  endtask : beat
endmodule : sgol_host_model

/* sgol_map.svh */
// Constant map of the sector guard and one-time area lock block.
// Assumes inclusion by bare name from any file that needs the figures.
`ifndef SGOL_MAP_SVH
`define SGOL_MAP_SVH

// ----------------------------------------------------------------------
// Command opcodes
// ----------------------------------------------------------------------
`define SGOL_OP_LOCK_RD 8'ha7
`define SGOL_OP_LOCK_WR 8'ha6
`define SGOL_OP_ANY_RD 8'h65
`define SGOL_OP_PG_RD 8'hfc
`define SGOL_OP_PG_RD4 8'he2
`define SGOL_OP_PG_PROG 8'hfd
`define SGOL_OP_PG_PROG4 8'he3
`define SGOL_OP_PG_ERASE 8'he4
`define SGOL_OP_DG_RD 8'hfa
`define SGOL_OP_DG_RD4 8'he0
`define SGOL_OP_DG_WR 8'hfb
`define SGOL_OP_DG_WR4 8'he1
`define SGOL_OP_OTP_PROG 8'h42
`define SGOL_OP_OTP_RD 8'h4b
`define SGOL_OP_PWD_UNLOCK 8'he9

// ----------------------------------------------------------------------
// Field positions, sizes and reset values
// ----------------------------------------------------------------------
`define SGOL_SECT_MSB 25
`define SGOL_SECT_LSB 18
`define SGOL_SECT_W 8
`define SGOL_SECTORS 256
`define SGOL_OTP_BYTES 1024
`define SGOL_OTP_AW 10
`define SGOL_OTP_CHUNKS 64
`define SGOL_LOCK_BASE 10'h010
`define SGOL_LOCK_ANY_ADDR 32'h0000_0009
`define SGOL_BOOT_SECTOR 8'h00
`define SGOL_GUARD_ON 8'h00
`define SGOL_GUARD_OFF 8'hff
`define SGOL_LOCK_RSVD 7'h00
`define SGOL_ASP_PASSWORD 2'h1
`define SGOL_PWD_BEATS 3'h7

`endif

/* sgol_pkg.sv */
// Types shared by the sector guard and one-time area lock block.
// Assumes nothing beyond a SystemVerilog compiler.
package sgol_pkg;

  // ----------------------------------------------------------------------
  // Start-up phase of the block
  // ----------------------------------------------------------------------
  typedef enum logic {SGOL_PH_INIT, SGOL_PH_RUN} sgol_phase_t;

  typedef logic [7:0] sgol_byte_t;
  typedef logic [31:0] sgol_addr_t;

endpackage : sgol_pkg

/* sgol_top.sv */
// Sector guard bits, guard lock flag and one-time area of a serial flash.
// Assumes a command decoder ahead of it that presents each command byte
// beat with its opcode and full address, synchronous to CLK.
`timescale 1ns/100ps
`include "sgol_map.svh"

module sgol_top (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [1:0] ASP_MODE_BITS,
  input wire logic RDPWD_MODE,
  input wire logic [63:0] HIDDEN_PWD,
  input wire logic FREEZE,
  input wire logic CMD_VALID,
  input wire logic CMD_FIRST,
  input wire sgol_pkg::sgol_byte_t CMD_OP,
  input wire sgol_pkg::sgol_addr_t CMD_ADDR,
  input wire sgol_pkg::sgol_byte_t CMD_DATA,
  input wire logic PERR_CLR,
  input wire sgol_pkg::sgol_addr_t ARRAY_ADDR,
  input wire sgol_pkg::sgol_addr_t RD_ADDR,
  output logic READY,
  output logic RSP_VALID,
  output sgol_pkg::sgol_byte_t RSP_DATA,
  output logic PROG_ERR,
  output logic LOCK_FLAG,
  output logic ARRAY_PROTECTED,
  output sgol_pkg::sgol_addr_t RD_ADDR_EFF,
  output logic OTP_ECC_OFF
);
  import sgol_pkg::*;

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------

  // Sector index carried by a main-array address.
  function automatic logic [`SGOL_SECT_W-1:0] sect_of(input sgol_addr_t a);
    return a[`SGOL_SECT_MSB:`SGOL_SECT_LSB];
  endfunction : sect_of

  // Guard bit as the byte that the host sees.
  function automatic sgol_byte_t guard_byte(input logic bit_val);
    return bit_val ? `SGOL_GUARD_OFF : `SGOL_GUARD_ON;
  endfunction : guard_byte

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  sgol_phase_t phase_reg;
  logic lock_reg;
  logic [`SGOL_SECTORS-1:0] pguard_reg;
  logic [`SGOL_SECTORS-1:0] dguard_reg;
  sgol_byte_t otp_mem [0:`SGOL_OTP_BYTES-1];
  logic [`SGOL_OTP_BYTES-1:0] otp_seen_reg;
  logic [63:0] pwd_reg;
  logic [2:0] pwd_cnt_reg;
  logic perr_reg;
  logic rsp_valid_reg;
  sgol_byte_t rsp_data_reg;
  logic prot_reg;
  sgol_addr_t rd_eff_reg;
  logic ecc_off_reg;
  logic [63:0] pwd_next;
  sgol_byte_t rsp_next;

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  logic run;
  logic pwd_mode;
  logic op_lock_rd, op_lock_wr, op_any_rd;
  logic op_pg_rd, op_pg_prog, op_pg_erase, op_dg_rd, op_dg_wr;
  logic op_otp_prog, op_otp_rd, op_pwd;
  logic [`SGOL_SECT_W-1:0] cmd_sect;
  logic [`SGOL_OTP_AW-1:0] otp_idx;
  logic otp_in_range;
  logic [4:0] region;
  sgol_byte_t lock_byte;
  logic region_locked;
  logic otp_write;
  logic perr_set;
  logic ecc_off_sel;

  assign run = (phase_reg == SGOL_PH_RUN) && CMD_VALID;
  assign pwd_mode = (ASP_MODE_BITS == `SGOL_ASP_PASSWORD);
  // Opcode decode, both address widths share one action.
  assign op_lock_rd = run && CMD_OP == `SGOL_OP_LOCK_RD;
  assign op_lock_wr = run && CMD_OP == `SGOL_OP_LOCK_WR;
  assign op_any_rd = run && CMD_OP == `SGOL_OP_ANY_RD;
  assign op_pg_rd = run && (CMD_OP == `SGOL_OP_PG_RD ||
                            CMD_OP == `SGOL_OP_PG_RD4);
  assign op_pg_prog = run && (CMD_OP == `SGOL_OP_PG_PROG ||
                              CMD_OP == `SGOL_OP_PG_PROG4);
  assign op_pg_erase = run && CMD_OP == `SGOL_OP_PG_ERASE;
  assign op_dg_rd = run && (CMD_OP == `SGOL_OP_DG_RD ||
                            CMD_OP == `SGOL_OP_DG_RD4);
  assign op_dg_wr = run && (CMD_OP == `SGOL_OP_DG_WR ||
                            CMD_OP == `SGOL_OP_DG_WR4);
  assign op_otp_prog = run && CMD_OP == `SGOL_OP_OTP_PROG;
  assign op_otp_rd = run && CMD_OP == `SGOL_OP_OTP_RD;
  assign op_pwd = run && CMD_OP == `SGOL_OP_PWD_UNLOCK;
  assign cmd_sect = sect_of(CMD_ADDR);

  // One-time area addressing: 32 regions of 32 bytes in 1 KB.
  assign otp_idx = CMD_ADDR[`SGOL_OTP_AW-1:0];
  assign otp_in_range = (CMD_ADDR[31:`SGOL_OTP_AW] == 22'h0);
  assign region = otp_idx[9:5];

  // Lock byte for the region, then its bit; region 0 guards only its top.
  assign lock_byte = otp_seen_reg[`SGOL_LOCK_BASE + {8'h00, region[4:3]}] ?
                     otp_mem[`SGOL_LOCK_BASE + {8'h00, region[4:3]}] :
                     8'hff;
  always_comb begin
    if (region == 5'h00) begin
      region_locked = otp_idx[4] && !lock_byte[0];
    end else begin
      region_locked = !lock_byte[region[2:0]];
    end
  end

  // Only the freeze flag and lock bytes gate the area, not the mode.
  assign otp_write = op_otp_prog && otp_in_range && !FREEZE &&
                     !region_locked;
  assign perr_set = (op_otp_prog && otp_in_range &&
                     (FREEZE || region_locked)) ||
                    ((op_pg_prog || op_pg_erase) && !lock_reg);

  // ----------------------------------------------------------------------
  // Start-up and guard lock flag
  // ----------------------------------------------------------------------

  // The mode straps are caught on the first edge after reset release.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      phase_reg <= SGOL_PH_INIT;
    end else begin
      case (phase_reg)
        SGOL_PH_INIT: phase_reg <= SGOL_PH_RUN;
        SGOL_PH_RUN: phase_reg <= SGOL_PH_RUN;
        default: phase_reg <= SGOL_PH_INIT;
      endcase
    end
  end

  // Lock flag: loaded from mode, cleared by command, set by password.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      lock_reg <= 1'b0;
    end else if (phase_reg == SGOL_PH_INIT) begin
      lock_reg <= !pwd_mode;
    end else if (op_lock_wr) begin
      lock_reg <= 1'b0;
    end else if (op_pwd && pwd_cnt_reg == `SGOL_PWD_BEATS && pwd_mode &&
                 pwd_next == HIDDEN_PWD) begin
      lock_reg <= 1'b1;
    end
  end

  // Password bytes arrive first byte lowest; eight beats form the word.
  assign pwd_next = {CMD_DATA, pwd_reg[63:8]};
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pwd_reg <= 64'h0;
      pwd_cnt_reg <= 3'h0;
    end else if (op_pwd) begin
      pwd_reg <= pwd_next;
      pwd_cnt_reg <= CMD_FIRST ? 3'h1 : 3'(pwd_cnt_reg + 3'h1);
    end
  end

  // ----------------------------------------------------------------------
  // Sector guard arrays
  // ----------------------------------------------------------------------

  // Persistent guards leave reset erased; only program and erase touch them.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pguard_reg <= {`SGOL_SECTORS{1'b1}};
    end else if (op_pg_erase && lock_reg) begin
      pguard_reg <= {`SGOL_SECTORS{1'b1}};
    end else if (op_pg_prog && lock_reg) begin
      pguard_reg[cmd_sect] <= 1'b0;
    end
  end

  // Dynamic guards start open; other data values leave the bit alone.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      dguard_reg <= {`SGOL_SECTORS{1'b1}};
    end else if (op_dg_wr && CMD_DATA == `SGOL_GUARD_ON) begin
      dguard_reg[cmd_sect] <= 1'b0;
    end else if (op_dg_wr && CMD_DATA == `SGOL_GUARD_OFF) begin
      dguard_reg[cmd_sect] <= 1'b1;
    end
  end

  // Array protection for the main-array address under program or erase.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      prot_reg <= 1'b0;
    end else begin
      prot_reg <= !pguard_reg[sect_of(ARRAY_ADDR)] ||
                  !dguard_reg[sect_of(ARRAY_ADDR)];
    end
  end

  // Read-password mode keeps reads inside the boot sector until unlock.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rd_eff_reg <= 32'h0;
    end else if (RDPWD_MODE && !lock_reg) begin
      rd_eff_reg <= {RD_ADDR[31:`SGOL_SECT_MSB+1], `SGOL_BOOT_SECTOR,
                     RD_ADDR[`SGOL_SECT_LSB-1:0]};
    end else begin
      rd_eff_reg <= RD_ADDR;
    end
  end

  // ----------------------------------------------------------------------
  // One-time area
  // ----------------------------------------------------------------------

  // Programming only pulls bits low; only reset, by clearing the seen marks, raises them again.
  always_ff @(posedge CLK) begin
    if (otp_write) begin
      otp_mem[otp_idx] <= (otp_seen_reg[otp_idx] ? otp_mem[otp_idx] :
                           8'hff) & CMD_DATA;
    end
  end

  // Marks bytes that hold programmed data; unseen bytes read as erased.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      otp_seen_reg <= {`SGOL_OTP_BYTES{1'b0}};
    end else if (otp_write) begin
      otp_seen_reg[otp_idx] <= 1'b1;
    end
  end

  // Code tracking for each 16-byte chunk.
  sgol_ecc_track sgol_ecc_track_i (
    .clk(CLK),
    .rst_b(RST_B),
    .prog(otp_write),
    .first(CMD_FIRST),
    .chunk(otp_idx[9:4]),
    .sel_chunk(otp_idx[9:4]),
    .ecc_off(ecc_off_sel)
  );

  // Code state reported with each one-time read.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ecc_off_reg <= 1'b0;
    end else if (op_otp_rd) begin
      ecc_off_reg <= ecc_off_sel;
    end
  end

  // Program error flag: a new error wins over a clear in the same cycle.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      perr_reg <= 1'b0;
    end else if (perr_set) begin
      perr_reg <= 1'b1;
    end else if (PERR_CLR) begin
      perr_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Read answers
  // ----------------------------------------------------------------------

  // Answer byte for the read command in this cycle.
  always_comb begin
    rsp_next = 8'h00;
    if (op_lock_rd || (op_any_rd && CMD_ADDR == `SGOL_LOCK_ANY_ADDR)) begin
      rsp_next = {`SGOL_LOCK_RSVD, lock_reg};
    end else if (op_pg_rd) begin
      rsp_next = guard_byte(pguard_reg[cmd_sect]);
    end else if (op_dg_rd) begin
      rsp_next = guard_byte(dguard_reg[cmd_sect]);
    end else if (op_otp_rd && otp_in_range) begin
      rsp_next = otp_seen_reg[otp_idx] ? otp_mem[otp_idx] : 8'hff;
    end
  end

  // One-cycle answer strobe after each read beat.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rsp_valid_reg <= 1'b0;
      rsp_data_reg <= 8'h00;
    end else begin
      rsp_valid_reg <= op_lock_rd || op_any_rd || op_pg_rd || op_dg_rd ||
                       op_otp_rd;
      rsp_data_reg <= rsp_next;
    end
  end

  assign READY = (phase_reg == SGOL_PH_RUN);
  assign RSP_VALID = rsp_valid_reg;
  assign RSP_DATA = rsp_data_reg;
  assign PROG_ERR = perr_reg;
  assign LOCK_FLAG = lock_reg;
  assign ARRAY_PROTECTED = prot_reg;
  assign RD_ADDR_EFF = rd_eff_reg;
  assign OTP_ECC_OFF = ecc_off_reg;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  // Refused persistent program leaves every guard bit unchanged.
  lock_refuse_a: assert property (
    (op_pg_prog || op_pg_erase) && !lock_reg
    |=> $stable(pguard_reg) && PROG_ERR)
    else $error("guard changed while locked");
  // Lock flag after start-up follows the mode straps.
  lock_start_a: assert property (
    phase_reg == SGOL_PH_INIT |=> LOCK_FLAG == !$past(pwd_mode))
    else $error("lock start value wrong");
  // Locked read-password mode points reads at the boot sector.
  boot_force_a: assert property (
    RDPWD_MODE && !LOCK_FLAG
    |=> sect_of(RD_ADDR_EFF) == `SGOL_BOOT_SECTOR)
    else $error("read escaped boot sector");
  // Lock read shows zero upper bits and the flag.
  lock_read_a: assert property (
    op_lock_rd |=> RSP_VALID && RSP_DATA == {7'h00, $past(lock_reg)})
    else $error("lock read wrong");
  // Persistent guard read encodes the bit as 00h or FFh.
  pg_read_a: assert property (
    op_pg_rd |=> RSP_DATA == guard_byte($past(pguard_reg[cmd_sect])))
    else $error("guard read wrong");
  // Dynamic write of 00h protects a sector on its next query.
  dg_write_a: assert property (
    op_dg_wr && CMD_DATA == 8'h00 && ARRAY_ADDR == CMD_ADDR
    ##1 $stable(ARRAY_ADDR) |=> ARRAY_PROTECTED)
    else $error("dynamic write missed");
  // Out-of-range one-time program leaves the flag and the area alone.
  otp_range_a: assert property (
    op_otp_prog && !otp_in_range && !PERR_CLR && !perr_set
    |=> PROG_ERR == $past(PROG_ERR) && $stable(otp_seen_reg))
    else $error("out of range raised error");
  // Frozen one-time program raises the error and writes nothing.
  otp_freeze_a: assert property (
    op_otp_prog && otp_in_range && FREEZE
    |=> PROG_ERR && $stable(otp_seen_reg))
    else $error("frozen program not refused");
  // Clearing command outside password mode keeps the flag low for two cycles.
  lock_clear_a: assert property (
    op_lock_wr && !pwd_mode |=> !LOCK_FLAG [*2])
    else $error("lock flag rose again");

  unlock_c: cover property (op_pwd ##1 LOCK_FLAG && !$past(LOCK_FLAG));
  ecc_off_c: cover property (op_otp_rd ##1 OTP_ECC_OFF);
  freeze_c: cover property (op_otp_prog && FREEZE ##1 PROG_ERR);

endmodule : sgol_top

/* sgol_top_bench.sv */
// Self-checking bench for the sector guard and one-time area block.
// Assumes sgol_pkg, sgol_host_model and the design files are compiled.
`timescale 1ns/100ps
module sgol_top_bench;
  import sgol_pkg::*;

  typedef struct packed {
    logic [7:0] op;
    logic [31:0] addr;
    logic [7:0] data;
    logic rd;
    logic [7:0] exp;
    logic err;
  } sgol_row_t;

  localparam logic [31:0] s1 = 32'h0004_0000;
  localparam logic [31:0] s2 = 32'h0008_0000;
  localparam logic [31:0] s3 = 32'h000c_0000;
  localparam logic [63:0] pwd = 64'h0f1e_2d3c_4b5a_6978;

  logic clk, rst_b, rdpwd_mode, freeze, perr_clr;
  logic [1:0] sector_protection_scheme;
  logic cmd_valid, cmd_first, ready, rsp_valid, prog_err, lock_flag;
  logic array_protected, ecc_off;
  sgol_byte_t cmd_op, cmd_data, rsp_data;
  sgol_addr_t cmd_addr, array_addr, rd_addr, rd_addr_eff;
  int failures, num_checks, cycles;

  // ----------------------------------------------------------------------
  // Ordinary cases, one command beat per row
  // ----------------------------------------------------------------------
  sgol_row_t rows [0:23] = '{
    '{8'ha7, 32'h0, 8'h00, 1'b1, 8'h01, 1'b0},
    '{8'h65, 32'h9, 8'h00, 1'b1, 8'h01, 1'b0},
    '{8'hfc, s1, 8'h00, 1'b1, 8'hff, 1'b0},
    '{8'hfd, s1, 8'h00, 1'b0, 8'h00, 1'b0},
    '{8'hfc, s1, 8'h00, 1'b1, 8'h00, 1'b0},
    '{8'he3, s2, 8'h00, 1'b0, 8'h00, 1'b0},
    '{8'he2, s2, 8'h00, 1'b1, 8'h00, 1'b0},
    '{8'he4, 32'h0, 8'h00, 1'b0, 8'h00, 1'b0},
    '{8'hfc, s1, 8'h00, 1'b1, 8'hff, 1'b0},
    '{8'hfa, s3, 8'h00, 1'b1, 8'hff, 1'b0},
    '{8'hfb, s3, 8'h00, 1'b0, 8'h00, 1'b0},
    '{8'he0, s3, 8'h00, 1'b1, 8'h00, 1'b0},
    '{8'he1, s3, 8'hff, 1'b0, 8'h00, 1'b0},
    '{8'hfa, s3, 8'h00, 1'b1, 8'hff, 1'b0},
    '{8'hfb, s3, 8'h5a, 1'b0, 8'h00, 1'b0},
    '{8'hfa, s3, 8'h00, 1'b1, 8'hff, 1'b0},
    '{8'h42, 32'h20, 8'ha5, 1'b0, 8'h00, 1'b0},
    '{8'h42, 32'h20, 8'ha5, 1'b0, 8'h00, 1'b0},
    '{8'h4b, 32'h20, 8'h00, 1'b1, 8'ha5, 1'b0},
    '{8'h42, 32'h400, 8'h11, 1'b0, 8'h00, 1'b0},
    '{8'ha6, 32'h0, 8'h00, 1'b0, 8'h00, 1'b0},
    '{8'ha7, 32'h0, 8'h00, 1'b1, 8'h00, 1'b0},
    '{8'hfd, s1, 8'h00, 1'b0, 8'h00, 1'b1},
    '{8'hfc, s1, 8'h00, 1'b1, 8'hff, 1'b0}
  };

  // ----------------------------------------------------------------------
  // Clock, parts and timeout
  // ----------------------------------------------------------------------
  // The clock toggles every half period of 5 ns.
  always #5 clk = ~clk;

  sgol_host_model sgol_host_model_i (.clk(clk), .cmd_valid(cmd_valid),
    .cmd_first(cmd_first), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data));

  sgol_top sgol_top_i (.CLK(clk), .RST_B(rst_b), .ASP_MODE_BITS(sector_protection_scheme),
    .RDPWD_MODE(rdpwd_mode), .HIDDEN_PWD(pwd), .FREEZE(freeze),
    .CMD_VALID(cmd_valid), .CMD_FIRST(cmd_first), .CMD_OP(cmd_op),
    .CMD_ADDR(cmd_addr), .CMD_DATA(cmd_data), .PERR_CLR(perr_clr),
    .ARRAY_ADDR(array_addr), .RD_ADDR(rd_addr), .READY(ready),
    .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .PROG_ERR(prog_err),
    .LOCK_FLAG(lock_flag), .ARRAY_PROTECTED(array_protected),
    .RD_ADDR_EFF(rd_addr_eff), .OTP_ECC_OFF(ecc_off));

  // A hung run is cut short well beyond the expected 180 or so cycles.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic clear_err;
    @(negedge clk);
    perr_clr = 1'b1;
    @(negedge clk);
    perr_clr = 1'b0;
  endtask : clear_err

  task automatic beat(input sgol_byte_t op, input sgol_addr_t a,
                      input sgol_byte_t d, input logic f);
    sgol_host_model_i.beat(op, a, d, f);
  endtask : beat

  // A one-time program whose error flag is checked, then cleared if an error is expected.
  task automatic prog_chk(input sgol_addr_t a, input logic e);
    beat(8'h42, a, 8'h3c, 1'b1);
    chk("prog_err", 32'(e), 32'(prog_err));
    if (e) clear_err();
  endtask : prog_chk

  task automatic rd_chk(input sgol_byte_t op, input sgol_addr_t a,
                        input sgol_byte_t e);
    beat(op, a, 8'h00, 1'b1);
    chk("rsp_valid", 32'h1, 32'(rsp_valid));
    chk("rsp_data", 32'(e), 32'(rsp_data));
  endtask : rd_chk

  // Outputs are zero in reset; the lock flag follows the mode bits after.
  task automatic do_reset(input logic [1:0] mode);
    sector_protection_scheme = mode;
    rst_b = 1'b0;
    repeat (8) @(negedge clk);
    chk("ready", 32'h0, 32'(ready));
    chk("lock_flag", 32'h0, 32'(lock_flag));
    rst_b = 1'b1;
    @(negedge clk);
    chk("ready", 32'h1, 32'(ready));
    chk("lock_flag", 32'(mode != 2'b01), 32'(lock_flag));
  endtask : do_reset

  task automatic send_pwd(input logic [63:0] p);
    for (int k = 0; k < 8; k++) begin
      beat(8'he9, 32'h0, p[8*k+:8], k == 0);
    end
    @(negedge clk);
  endtask : send_pwd

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    sector_protection_scheme = 2'b11;
    rdpwd_mode = 1'b0;
    freeze = 1'b0;
    perr_clr = 1'b0;
    array_addr = 32'h0;
    rd_addr = 32'h0;
    failures = 0;
    num_checks = 0;
    cycles = 0;
    do_reset(2'b11);
    for (int i = 0; i < 24; i++) begin
      beat(rows[i].op, rows[i].addr, rows[i].data, 1'b1);
      chk("rsp_valid", 32'(rows[i].rd), 32'(rsp_valid));
      if (rows[i].rd) begin
        chk("rsp_data", 32'(rows[i].exp), 32'(rsp_data));
      end
      chk("prog_err", 32'(rows[i].err), 32'(prog_err));
      if (rows[i].err) clear_err();
    end
    // Generic read elsewhere answers zero; a password is ignored here.
    rd_chk(8'h65, 32'h0, 8'h00);
    send_pwd(pwd);
    chk("lock_flag", 32'h0, 32'(lock_flag));
    // Locked read-password mode confines reads to the boot sector.
    rd_addr = 32'h0123_4567;
    rdpwd_mode = 1'b1;
    repeat (2) @(negedge clk);
    chk("rd_addr_eff", 32'h0003_4567, rd_addr_eff);
    rdpwd_mode = 1'b0;
    repeat (2) @(negedge clk);
    chk("rd_addr_eff", rd_addr, rd_addr_eff);
    // A cleared dynamic bit protects the sector; a set one releases it.
    array_addr = s3;
    beat(8'hfb, s3, 8'h00, 1'b1);
    @(negedge clk);
    chk("array_protected", 32'h1, 32'(array_protected));
    beat(8'hfb, s3, 8'hff, 1'b1);
    @(negedge clk);
    chk("array_protected", 32'h0, 32'(array_protected));
    // The freeze flag guards the one-time area; the cleared lock flag does not.
    freeze = 1'b1;
    prog_chk(32'h40, 1'b1);
    freeze = 1'b0;
    prog_chk(32'h40, 1'b0);
    // A second command in a chunk turns its code off; one command does not.
    beat(8'h42, 32'h60, 8'h11, 1'b1);
    beat(8'h42, 32'h61, 8'h22, 1'b1);
    beat(8'h42, 32'h80, 8'h33, 1'b1);
    beat(8'h42, 32'h81, 8'h44, 1'b0);
    rd_chk(8'h4b, 32'h80, 8'h33);
    @(negedge clk);
    chk("ecc_off", 32'h0, 32'(ecc_off));
    rd_chk(8'h4b, 32'h61, 8'h22);
    @(negedge clk);
    chk("ecc_off", 32'h1, 32'(ecc_off));
    // Lock byte bits 0 and 1 guard region zero's top and region one.
    prog_chk(32'h10, 1'b0);
    prog_chk(32'h30, 1'b1);
    prog_chk(32'h18, 1'b1);
    prog_chk(32'h05, 1'b0);
    prog_chk(32'h48, 1'b0);
    // Password mode starts locked and opens only on a matching password.
    do_reset(2'b01);
    rd_chk(8'hfa, s3, 8'hff);
    rd_chk(8'hfc, s1, 8'hff);
    send_pwd(~pwd);
    chk("lock_flag", 32'h0, 32'(lock_flag));
    send_pwd(pwd);
    chk("lock_flag", 32'h1, 32'(lock_flag));
    beat(8'hfd, s2, 8'h00, 1'b1);
    chk("prog_err", 32'h0, 32'(prog_err));
    array_addr = s2;
    repeat (2) @(negedge clk);
    chk("array_protected", 32'h1, 32'(array_protected));
    rd_chk(8'hfc, s2, 8'h00);
    // Unlocked read-password mode passes the address; a clear re-forces.
    rdpwd_mode = 1'b1;
    repeat (2) @(negedge clk);
    chk("rd_addr_eff", 32'h0123_4567, rd_addr_eff);
    beat(8'ha6, 32'h0, 8'h00, 1'b1);
    chk("lock_flag", 32'h0, 32'(lock_flag));
    @(negedge clk);
    chk("rd_addr_eff", 32'h0003_4567, rd_addr_eff);
    print_verdict();
  end
endmodule : sgol_top_bench
